//--- sbm_baud_gen.v
// Baud tick generator: one tick per half bit period
`timescale 1ns/1ps
`default_nettype none
module sbm_baud_gen
(
   input wire clk,
   input wire srst,
   input wire run,
   input wire [15:0] div,
   output reg tick
);
   reg [15:0] cnt_q;

   // Restart while idle so the first tick falls div+1 cycles after start
   always @(posedge clk)
   begin
      if (srst)
      begin
         cnt_q <= 16'h0000;
         tick <= 1'b0;
      end
      else if (!run)
      begin
         cnt_q <= div;
         tick <= 1'b0;
      end
      else if (cnt_q == 16'h0000)
      begin
         cnt_q <= div;
         tick <= 1'b1;
      end
      else
      begin
         cnt_q <= cnt_q - 16'h0001;
         tick <= 1'b0;
      end
   end
endmodule
`default_nettype wire

//--- sbm_map.vh
// Register offsets, bit positions, reset values and frame constants
`ifndef SBM_MAP_VH
`define SBM_MAP_VH

// Byte offsets on the register bus, one 32-bit word per register
`define SBM_OFS_FLAGS 6'h00
`define SBM_OFS_INTEN 6'h04
`define SBM_OFS_RXCTL 6'h08
`define SBM_OFS_TXBUF 6'h0C
`define SBM_OFS_TXCTL 6'h10
`define SBM_OFS_BAUD 6'h14
`define SBM_OFS_DIVH 6'h18
`define SBM_OFS_DIVL 6'h1C
`define SBM_OFS_RXBUF 6'h20

// peripheral_flag_bank and peripheral_int_enable_bank
`define SBM_FLG_RXDONE 5
`define SBM_FLG_TXEMPTY 4

// receive_control
`define SBM_RC_PEN 7
`define SBM_RC_RX9 6
`define SBM_RC_SINGLE_RECEIVE_EN 5
`define SBM_RC_CONTINUOUS_RECEIVE_EN 4
`define SBM_RC_ADDEN 3
`define SBM_RC_FERR 2
`define SBM_RC_OERR 1
`define SBM_RC_RX9D 0

// transmit_control
`define SBM_TC_CLOCK_SOURCE_MASTER 7
`define SBM_TC_TX9 6
`define SBM_TC_TRANSMIT_ENABLE 5
`define SBM_TC_SYNC 4
`define SBM_TC_BRK 3
`define SBM_TC_BRGH 2
`define SBM_TC_SHIFTER_EMPTY 1
`define SBM_TC_TRANSMIT_NINTH_BIT 0

// baud_control
`define SBM_BC_RXIDLE 6
`define SBM_BC_POL 4
`define SBM_BC_WIDE 3
`define SBM_BC_WUE 1
`define SBM_BC_ABD 0

// Writable bits of each register
`define SBM_WM_INTEN 8'h30
`define SBM_WM_RXCTL 8'hF8
`define SBM_WM_TXCTL 8'hFD
`define SBM_WM_BAUD 8'h1B

// Reset values
`define SBM_RST_REG 8'h00
`define SBM_RST_DIV 8'h00

// Break frame: start, twelve zeros, stop (bit 13 is the stop bit)
`define SBM_BREAK_ZEROS 12
`define SBM_BRK_FRAME 14'h2000
`define SBM_BRK_BITS 4'hE
`define SBM_ASYNC_BITS8 4'hA
`define SBM_ASYNC_BITS9 4'hB
`define SBM_SYNC_BITS8 4'h8
`define SBM_SYNC_BITS9 4'h9

// Buffer-to-shifter transfer time in clock cycles
`define SBM_XFER_CYCLES 1

`endif

//--- sbm_peer.sv
// Far-side clocked serial peripheral model
`timescale 1ns/1ps
`default_nettype none
module sbm_peer
(
   input wire logic clk,
   input wire logic sck,
   input wire logic dt_oe,
   input wire logic dt_in,
   input wire logic pol,
   input wire logic load,
   input wire logic [7:0] word,
   output var logic dt_q,
   output var logic [7:0] got_q,
   output var logic [4:0] cnt_q
);
   logic sck_q;
   logic [7:0] sh_q;
   logic [4:0] idle_q;
   initial dt_q = 1'b0;
   initial sck_q = 1'b1;
   initial idle_q = 5'h00;
   always @(posedge clk)
   begin
      sck_q <= sck;
      // Only a clock quiet for a long time counts as outside a frame
      if (sck != sck_q)
         idle_q <= 5'h00;
      else if (idle_q != 5'h1F)
         idle_q <= idle_q + 5'h01;
      if (load)
      begin
         sh_q <= word;
         cnt_q <= 5'h00;
      end
      else if (sck_q == pol && sck != pol && !dt_oe)
      begin
         dt_q <= sh_q[0];
         sh_q <= {~sh_q[0], sh_q[7:1]};
      end
      else if (sck_q != pol && sck == pol && dt_oe)
      begin
         got_q <= {dt_in, got_q[7:1]};
         cnt_q <= cnt_q + 5'h01;
      end
      else if (!dt_oe && sck == pol && idle_q == 5'h1F)
         dt_q <= ~dt_q; // Idle line carries no stale value
   end
endmodule
`default_nettype wire

//--- sbm_serial_port.v
// Break sender, wake-on-edge and clocked master serial port
// Overview of operation
// - Break is start, twelve zeros, stop
// - Break request with enable sends zeros
// - Break request self-clears after break stop bit
// - Next byte buffered during break, sent after
// - Shifter-empty behaves same during break
// - Wake: falling edge flags, then byte
// - Master, clocked, port enable select pins
// - Clocked data line is half duplex
// - Master drives clock, idle level per polarity
// - Shifter loads only after last bit
// - Transfer takes one cycle, then flag
// - Buffer-empty flag cleared only by writes
// - Shifter-empty read-only, no interrupt
// - Shifter not visible to software
// - Single receive one word, continuous repeats
// - Receive flag, ninth bit, errors exposed
// - Clearing continuous receive clears errors
// - Unimplemented bits read as zero
// - Wake ends on rising edge after wake
`timescale 1ns/1ps
`default_nettype none
`include "sbm_map.vh"
module sbm_serial_port
(
   input wire CLK,
   input wire SRST,
   input wire [5:0] AVS_ADDRESS,
   input wire AVS_READ,
   input wire AVS_WRITE,
   input wire [31:0] AVS_WRITEDATA,
   output reg [31:0] AVS_READDATA,
   output reg AVS_WAITREQUEST,
   output reg PIN_TXCK_O,
   output reg PIN_TXCK_OE,
   input wire PIN_RXDT_I,
   output reg PIN_RXDT_O,
   output reg PIN_RXDT_OE
);
   localparam RX_IDLE = 2'b00;
   localparam RX_ASYNC = 2'b01;
   localparam RX_SYNC = 2'b10;

   reg [7:0] inten_q, rxctl_q, txctl_q, baud_q, divh_q, divl_q;
   reg [7:0] txbuf_q, rxbuf_q;
   reg txfull_q, rxdone_q, ferr_q, oerr_q, rx9d_q, wake_seen_q;
   reg [13:0] tsr_q;
   reg [3:0] tx_cnt_q, rx_cnt_q;
   reg tx_busy_q, tx_brk_q, tx_ph_q, rx_ph_q;
   reg [1:0] rx_st_q;
   reg [8:0] rx_sh_q;
   reg rx_s1_q, rx_s2_q, rx_prev_q;
   reg [7:0] rd_d;

   wire wr_en = AVS_WRITE & ~AVS_WAITREQUEST;
   wire rd_en = AVS_READ & ~AVS_WAITREQUEST;
   wire wr_txbuf = wr_en & (AVS_ADDRESS == `SBM_OFS_TXBUF);
   wire wr_rxctl = wr_en & (AVS_ADDRESS == `SBM_OFS_RXCTL);
   wire wr_txctl = wr_en & (AVS_ADDRESS == `SBM_OFS_TXCTL);
   wire wr_baud = wr_en & (AVS_ADDRESS == `SBM_OFS_BAUD);
   wire rd_rxbuf = rd_en & (AVS_ADDRESS == `SBM_OFS_RXBUF);

   wire pen = rxctl_q[`SBM_RC_PEN];
   wire rx9 = rxctl_q[`SBM_RC_RX9];
   wire single_receive_en = rxctl_q[`SBM_RC_SINGLE_RECEIVE_EN];
   wire continuous_receive_en = rxctl_q[`SBM_RC_CONTINUOUS_RECEIVE_EN];
   wire master = txctl_q[`SBM_TC_CLOCK_SOURCE_MASTER];
   wire tx9 = txctl_q[`SBM_TC_TX9];
   wire transmit_enable = txctl_q[`SBM_TC_TRANSMIT_ENABLE];
   wire syncm = txctl_q[`SBM_TC_SYNC];
   wire brk_req = txctl_q[`SBM_TC_BRK];
   wire pol = baud_q[`SBM_BC_POL];
   wire wake_on_edge_en = baud_q[`SBM_BC_WUE];
   wire sync_master = pen & syncm & master;

   wire tick;
   wire baud_run = pen & (tx_busy_q | (rx_st_q != RX_IDLE));
   wire [15:0] div = baud_q[`SBM_BC_WIDE] ? {divh_q, divl_q}
                                          : {8'h00, divl_q};

   sbm_baud_gen u_baud
   (
      .clk(CLK),
      .srst(SRST),
      .run(baud_run),
      .div(div),
      .tick(tick)
   );

   wire rx_line = rx_s2_q;
   wire rx_fall = rx_prev_q & ~rx_s2_q;
   wire rx_rise = ~rx_prev_q & rx_s2_q;

   // Loading waits for the shifter to finish and, when clocked, for receive
   wire tx_load = pen & transmit_enable & txfull_q & ~tx_busy_q
                  & ~(syncm & (rx_st_q != RX_IDLE));
   wire load_brk = tx_load & brk_req & ~syncm;
   wire tx_bit_end = tx_busy_q & tick & tx_ph_q;
   wire tx_last = tx_bit_end & (tx_cnt_q == 4'h1);
   wire brk_done = tx_last & tx_brk_q;

   wire async_rx_ok = pen & ~syncm & continuous_receive_en & ~wake_on_edge_en & ~oerr_q;
   wire sync_rx_ok = sync_master & (single_receive_en | continuous_receive_en) & ~oerr_q & ~tx_busy_q
                     & ~txfull_q;
   wire [3:0] rx_bits = rx9 ? 4'h9 : 4'h8;
   reg rx_complete;
   reg rx_ferr;
   wire [8:0] rx_word = (rx_st_q == RX_SYNC) ? {rx_line, rx_sh_q[8:1]}
                                             : rx_sh_q;

   // Two-stage synchroniser on the data pin, edges taken after it
   always @(posedge CLK)
   begin
      if (SRST)
      begin
         rx_s1_q <= 1'b1;
         rx_s2_q <= 1'b1;
         rx_prev_q <= 1'b1;
      end
      else
      begin
         rx_s1_q <= PIN_RXDT_I;
         rx_s2_q <= rx_s1_q;
         rx_prev_q <= rx_s2_q;
      end
   end

   // Register bus: waitrequest drops for one cycle per request
   always @*
   begin
      rd_d = 8'h00;
      case (AVS_ADDRESS)
         `SBM_OFS_FLAGS:
            rd_d = {2'b00, rxdone_q, ~txfull_q, 4'h0};
         `SBM_OFS_INTEN:
            rd_d = inten_q;
         `SBM_OFS_RXCTL:
            rd_d = {rxctl_q[7:3], ferr_q, oerr_q, rx9d_q};
         `SBM_OFS_TXBUF:
            rd_d = txbuf_q;
         `SBM_OFS_TXCTL:
            rd_d = {txctl_q[7:2], ~tx_busy_q, txctl_q[0]};
         `SBM_OFS_BAUD:
            rd_d = {1'b0, (rx_st_q == RX_IDLE), 1'b0, baud_q[4:3], 1'b0,
                    baud_q[1:0]};
         `SBM_OFS_DIVH:
            rd_d = divh_q;
         `SBM_OFS_DIVL:
            rd_d = divl_q;
         `SBM_OFS_RXBUF:
            rd_d = rxbuf_q;
         default:
            rd_d = 8'h00;
      endcase
   end

   always @(posedge CLK)
   begin
      if (SRST)
      begin
         AVS_WAITREQUEST <= 1'b1;
         AVS_READDATA <= 32'h00000000;
      end
      else if ((AVS_READ | AVS_WRITE) & AVS_WAITREQUEST)
      begin
         AVS_WAITREQUEST <= 1'b0;
         AVS_READDATA <= {24'h000000, rd_d};
      end
      else
      begin
         AVS_WAITREQUEST <= 1'b1;
      end
   end

   // Software registers; the shifter itself has no address
   always @(posedge CLK)
   begin
      if (SRST)
      begin
         inten_q <= `SBM_RST_REG;
         rxctl_q <= `SBM_RST_REG;
         txctl_q <= `SBM_RST_REG;
         baud_q <= `SBM_RST_REG;
         divh_q <= `SBM_RST_DIV;
         divl_q <= `SBM_RST_DIV;
      end
      else
      begin
         if (wr_en & (AVS_ADDRESS == `SBM_OFS_INTEN))
            inten_q <= AVS_WRITEDATA[7:0] & `SBM_WM_INTEN;
         if (wr_en & (AVS_ADDRESS == `SBM_OFS_DIVH))
            divh_q <= AVS_WRITEDATA[7:0];
         if (wr_en & (AVS_ADDRESS == `SBM_OFS_DIVL))
            divl_q <= AVS_WRITEDATA[7:0];
         if (wr_rxctl)
            rxctl_q <= AVS_WRITEDATA[7:0] & `SBM_WM_RXCTL;
         else if (rx_complete & (rx_st_q == RX_SYNC) & ~continuous_receive_en)
            rxctl_q[`SBM_RC_SINGLE_RECEIVE_EN] <= 1'b0;
         // A software write of the break request beats the hardware clear
         if (wr_txctl)
            txctl_q <= AVS_WRITEDATA[7:0] & `SBM_WM_TXCTL;
         else if (brk_done)
            txctl_q[`SBM_TC_BRK] <= 1'b0;
         if (wr_baud)
            baud_q <= AVS_WRITEDATA[7:0] & `SBM_WM_BAUD;
         else if (wake_on_edge_en & wake_seen_q & rx_rise)
            baud_q[`SBM_BC_WUE] <= 1'b0;
      end
   end

   // Transmit buffer: empty flag follows the buffer, not software
   always @(posedge CLK)
   begin
      if (SRST)
      begin
         txbuf_q <= 8'h00;
         txfull_q <= 1'b0;
      end
      else if (wr_txbuf)
      begin
         txbuf_q <= AVS_WRITEDATA[7:0];
         txfull_q <= 1'b1;
      end
      else if (tx_load)
      begin
         txfull_q <= 1'b0;
      end
   end

   // Transmit shifter: each bit lasts two ticks, low bit goes first
   always @(posedge CLK)
   begin
      if (SRST)
      begin
         tsr_q <= 14'h3FFF;
         tx_cnt_q <= 4'h0;
         tx_busy_q <= 1'b0;
         tx_brk_q <= 1'b0;
         tx_ph_q <= 1'b0;
      end
      else if (tx_load)
      begin
         tx_busy_q <= 1'b1;
         tx_ph_q <= 1'b0;
         tx_brk_q <= load_brk;
         if (load_brk)
         begin
            tsr_q <= `SBM_BRK_FRAME;
            tx_cnt_q <= `SBM_BRK_BITS;
         end
         else if (syncm)
         begin
            tsr_q <= {5'h1F, txctl_q[`SBM_TC_TRANSMIT_NINTH_BIT], txbuf_q};
            tx_cnt_q <= tx9 ? `SBM_SYNC_BITS9 : `SBM_SYNC_BITS8;
         end
         else
         begin
            tsr_q <= {3'h7, 1'b1, tx9 ? txctl_q[`SBM_TC_TRANSMIT_NINTH_BIT] : 1'b1,
                      txbuf_q, 1'b0};
            tx_cnt_q <= tx9 ? `SBM_ASYNC_BITS9 : `SBM_ASYNC_BITS8;
         end
      end
      else if (tx_busy_q & tick)
      begin
         tx_ph_q <= ~tx_ph_q;
         if (tx_ph_q)
         begin
            tsr_q <= {1'b1, tsr_q[13:1]};
            tx_cnt_q <= tx_cnt_q - 4'h1;
            if (tx_last)
            begin
               tx_busy_q <= 1'b0;
               tx_brk_q <= 1'b0;
            end
         end
      end
      else if (!pen)
      begin
         tx_busy_q <= 1'b0;
         tx_brk_q <= 1'b0;
      end
   end

   // Completion of a received word in either mode
   always @*
   begin
      rx_complete = 1'b0;
      rx_ferr = 1'b0;
      if (tick & (rx_st_q == RX_ASYNC) & ~rx_ph_q
          & (rx_cnt_q == rx_bits + 4'h1))
      begin
         rx_complete = 1'b1;
         rx_ferr = ~rx_line;
      end
      else if (tick & (rx_st_q == RX_SYNC) & rx_ph_q
               & (rx_cnt_q == rx_bits - 4'h1))
      begin
         rx_complete = 1'b1;
      end
   end

   // Receiver and wake-on-edge
   always @(posedge CLK)
   begin
      if (SRST)
      begin
         rx_st_q <= RX_IDLE;
         rx_cnt_q <= 4'h0;
         rx_ph_q <= 1'b0;
         rx_sh_q <= 9'h000;
      end
      else
      begin
         case (rx_st_q)
            RX_IDLE:
            begin
               rx_cnt_q <= 4'h0;
               rx_ph_q <= 1'b0;
               if (sync_rx_ok)
                  rx_st_q <= RX_SYNC;
               else if (async_rx_ok & rx_fall)
                  rx_st_q <= RX_ASYNC;
            end
            RX_ASYNC:
            begin
               if (!pen | syncm)
                  rx_st_q <= RX_IDLE;
               else if (tick)
               begin
                  rx_ph_q <= ~rx_ph_q;
                  if (!rx_ph_q)
                  begin
                     rx_cnt_q <= rx_cnt_q + 4'h1;
                     if ((rx_cnt_q == 4'h0) & rx_line)
                        rx_st_q <= RX_IDLE;
                     else if (rx_cnt_q != 4'h0)
                        rx_sh_q <= {rx_line, rx_sh_q[8:1]};
                     if (rx_complete)
                        rx_st_q <= RX_IDLE;
                  end
               end
            end
            RX_SYNC:
            begin
               if (!sync_master)
                  rx_st_q <= RX_IDLE;
               else if (tick)
               begin
                  rx_ph_q <= ~rx_ph_q;
                  if (rx_ph_q)
                  begin
                     rx_sh_q <= {rx_line, rx_sh_q[8:1]};
                     rx_cnt_q <= rx_cnt_q + 4'h1;
                     if (rx_complete)
                        rx_st_q <= RX_IDLE;
                  end
               end
            end
            default:
               rx_st_q <= RX_IDLE;
         endcase
      end
   end

   // Receive flag: a wake edge wins over the clear by reading the buffer, a word completing while set does not
   always @(posedge CLK)
   begin
      if (SRST)
      begin
         rxbuf_q <= 8'h00;
         rxdone_q <= 1'b0;
         ferr_q <= 1'b0;
         oerr_q <= 1'b0;
         rx9d_q <= 1'b0;
         wake_seen_q <= 1'b0;
      end
      else
      begin
         if (rx_complete & ~rxdone_q)
         begin
            rxdone_q <= 1'b1;
            rxbuf_q <= rx9 ? rx_word[7:0] : rx_word[8:1];
            rx9d_q <= rx9 & rx_word[8];
            ferr_q <= rx_ferr;
         end
         else if (wake_on_edge_en & pen & ~syncm & ~wake_seen_q & rx_fall)
            rxdone_q <= 1'b1;
         else if (rd_rxbuf)
            rxdone_q <= 1'b0;
         if (wake_on_edge_en & pen & ~syncm & ~wake_seen_q & rx_fall)
            wake_seen_q <= 1'b1;
         else if (~wake_on_edge_en | rx_rise)
            wake_seen_q <= 1'b0;
         // Overrun keeps the unread word and stops reception until cleared
         if (rx_complete & rxdone_q)
            oerr_q <= 1'b1;
         else if (wr_rxctl & ~AVS_WRITEDATA[`SBM_RC_CONTINUOUS_RECEIVE_EN])
         begin
            oerr_q <= 1'b0;
            ferr_q <= 1'b0;
         end
      end
   end

   // Pin drivers, registered so the pins never glitch
   always @(posedge CLK)
   begin
      if (SRST)
      begin
         PIN_TXCK_O <= 1'b1;
         PIN_TXCK_OE <= 1'b0;
         PIN_RXDT_O <= 1'b1;
         PIN_RXDT_OE <= 1'b0;
      end
      else
      begin
         PIN_TXCK_OE <= pen & (master | ~syncm);
         PIN_RXDT_OE <= sync_master & tx_busy_q;
         PIN_RXDT_O <= tsr_q[0];
         if (sync_master)
         begin
            if ((tx_busy_q & ~tx_ph_q) | ((rx_st_q == RX_SYNC) & ~rx_ph_q))
               PIN_TXCK_O <= ~pol;
            else
               PIN_TXCK_O <= pol;
         end
         else
            PIN_TXCK_O <= tx_busy_q ? tsr_q[0] : 1'b1;
      end
   end
endmodule
`default_nettype wire

//--- sbm_serial_port_properties.sv
// Checker for bus handshake, pin modes and break length
`timescale 1ns/1ps
`default_nettype none
`include "sbm_map.vh"
module sbm_serial_port_properties
(
   input wire CLK,
   input wire SRST,
   input wire [5:0] AVS_ADDRESS,
   input wire AVS_READ,
   input wire AVS_WRITE,
   input wire [31:0] AVS_WRITEDATA,
   input wire [31:0] AVS_READDATA,
   input wire AVS_WAITREQUEST,
   input wire PIN_TXCK_O,
   input wire PIN_TXCK_OE,
   input wire PIN_RXDT_I,
   input wire PIN_RXDT_O,
   input wire PIN_RXDT_OE
);
   logic [7:0] div_q;
   logic sync_q;
   logic pol_q;
   logic [12:0] low_q;
   logic ack_w;
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (SRST);
   // Shadow only the low divider byte: wide mode is left out here
   assign ack_w = AVS_WRITE && !AVS_WAITREQUEST;
   always @(posedge CLK)
   begin
      if (SRST)
      begin
         div_q <= 8'h00;
         sync_q <= 1'b0;
         pol_q <= 1'b0;
      end
      else if (ack_w && AVS_ADDRESS == `SBM_OFS_DIVL)
         div_q <= AVS_WRITEDATA[7:0];
      else if (ack_w && AVS_ADDRESS == `SBM_OFS_TXCTL)
         sync_q <= AVS_WRITEDATA[`SBM_TC_SYNC];
      else if (ack_w && AVS_ADDRESS == `SBM_OFS_BAUD)
         pol_q <= AVS_WRITEDATA[`SBM_BC_POL];
      if (SRST || PIN_TXCK_O)
         low_q <= 13'h0000;
      else
         low_q <= low_q + 13'h0001;
   end
   property p_ack_next;
      (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST;
   endproperty
   a_ack_next: assert property (p_ack_next)
      else $error("request not answered one cycle later");
   property p_ack_once;
      !AVS_WAITREQUEST |=> AVS_WAITREQUEST;
   endproperty
   a_ack_once: assert property (p_ack_once)
      else $error("waitrequest low longer than one cycle");
   property p_upper_zero;
      !AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h000000;
   endproperty
   a_upper_zero: assert property (p_upper_zero)
      else $error("upper read data bits not zero");
   property p_unmapped;
      AVS_READ && AVS_WAITREQUEST && AVS_ADDRESS > `SBM_OFS_RXBUF
         |=> AVS_READDATA == 32'h00000000;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   property p_dt_mode;
      PIN_RXDT_OE |-> PIN_TXCK_OE && sync_q;
   endproperty
   a_dt_mode: assert property (p_dt_mode)
      else $error("data line driven outside clocked master mode");
   property p_release;
      $fell(SRST) |-> !PIN_RXDT_OE && !PIN_TXCK_OE && PIN_TXCK_O;
   endproperty
   a_release: assert property (p_release)
      else $error("pins not idle after reset");
   property p_break_len;
      $rose(PIN_TXCK_O) && !sync_q
         |-> low_q <= 13'h001A * ({5'h00, div_q} + 13'h0001) + 13'h0001;
   endproperty
   a_break_len: assert property (p_break_len)
      else $error("transmit line low longer than a break");
   property p_dt_setup;
      sync_q && PIN_RXDT_OE && $past(PIN_RXDT_OE) && $changed(PIN_RXDT_O)
         |-> PIN_TXCK_O == pol_q || $past(PIN_TXCK_O) == pol_q;
   endproperty
   a_dt_setup: assert property (p_dt_setup)
      else $error("data changed mid active clock phase");
endmodule
bind sbm_serial_port sbm_serial_port_properties i_sbm_serial_port_properties
(
   .CLK(CLK),
   .SRST(SRST),
   .AVS_ADDRESS(AVS_ADDRESS),
   .AVS_READ(AVS_READ),
   .AVS_WRITE(AVS_WRITE),
   .AVS_WRITEDATA(AVS_WRITEDATA),
   .AVS_READDATA(AVS_READDATA),
   .AVS_WAITREQUEST(AVS_WAITREQUEST),
   .PIN_TXCK_O(PIN_TXCK_O),
   .PIN_TXCK_OE(PIN_TXCK_OE),
   .PIN_RXDT_I(PIN_RXDT_I),
   .PIN_RXDT_O(PIN_RXDT_O),
   .PIN_RXDT_OE(PIN_RXDT_OE)
);
`default_nettype wire

//--- test_sbm_serial_port.sv
// Self-checking bench for the serial port
`timescale 1ns/1ps
`default_nettype none
`include "sbm_map.vh"
module test_sbm_serial_port;
   logic clk, srst, rd, wr, wait_rq, txck_o, txck_oe, rxdt_o, rxdt_oe;
   logic pol, pload, peer_dt, rx_line;
   logic [5:0] addr;
   logic [31:0] wdata, rdata, seed;
   logic [7:0] pword, got, div, d1, d2, v;
   logic [4:0] pcnt;
   logic [1:0] line_mode;
   int fails, check_count, run, last_low, bl, i, p, n;
   sbm_serial_port i_sbm_serial_port (.CLK(clk), .SRST(srst),
      .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
      .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata),
      .AVS_WAITREQUEST(wait_rq), .PIN_TXCK_O(txck_o),
      .PIN_TXCK_OE(txck_oe), .PIN_RXDT_I(rx_line),
      .PIN_RXDT_O(rxdt_o), .PIN_RXDT_OE(rxdt_oe));
   sbm_peer i_sbm_peer (.clk(clk), .sck(txck_o), .dt_oe(rxdt_oe),
      .dt_in(rx_line), .pol(pol), .load(pload), .word(pword),
      .dt_q(peer_dt), .got_q(got), .cnt_q(pcnt));
   assign rx_line = rxdt_oe ? rxdt_o : line_mode == 2'h1 ? 1'b0 :
      line_mode == 2'h2 ? 1'b1 : peer_dt;
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   function automatic logic [7:0] rst_val(input logic [5:0] a);
      return a == `SBM_OFS_FLAGS ? 8'h10 : a == `SBM_OFS_TXCTL ? 8'h02 : 8'h00;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic summarize;
      $display("Counts: %0d compared, %0d mismatched", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic give_up;
      fails++;
      summarize;
   endtask
   task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
      int k;
      @(posedge clk);
      addr <= a;
      wr <= w;
      rd <= !w;
      wdata <= {24'h000000, d};
      k = 0;
      do
      begin
         @(negedge clk);
         k++;
      end
      while (wait_rq !== 1'b0 && k < 50);
      if (k == 50)
         give_up;
      v = rdata[7:0];
      check(rdata[31:8], 24'h000000);
      @(posedge clk);
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      check(v, e);
   endtask
   task automatic wait_tx(input logic lvl);
      int k;
      for (k = 0; txck_o !== lvl && k < 20000; k++)
         @(posedge clk);
      if (k == 20000)
         give_up;
   endtask
   task automatic wait_cnt(input logic [4:0] c);
      int k;
      for (k = 0; pcnt !== c && k < 20000; k++)
         @(posedge clk);
      if (k == 20000)
         give_up;
   endtask
   always @(posedge clk)
   begin
      if (txck_o === 1'b0)
         run <= run + 1;
      else
      begin
         if (run != 0)
            last_low <= run;
         run <= 0;
      end
   end
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial
   begin
      repeat (100000) @(posedge clk);
      give_up;
   end
   initial
   begin
      {srst, rd, wr, pload, pol} = 5'h10;
      addr = 6'h00;
      wdata = 32'h0;
      pword = 8'h00;
      line_mode = 2'h2;
      seed = 32'h12;
      run = 0;
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      for (n = 0; n <= 9; n++)
         if (n != 5)
            rd_chk(n * 4, rst_val(n * 4));
      wr_reg(`SBM_OFS_INTEN, 8'hFF);
      rd_chk(`SBM_OFS_INTEN, 8'h30);
      wr_reg(`SBM_OFS_FLAGS, 8'h00);
      rd_chk(`SBM_OFS_FLAGS, 8'h10);
      $display("test registers done");
      div = rnd() & 8'h03;
      bl = 2 * (div + 1);
      wr_reg(`SBM_OFS_DIVL, div);
      wr_reg(`SBM_OFS_RXCTL, 8'h80);
      wr_reg(`SBM_OFS_TXCTL, 8'h28);
      wr_reg(`SBM_OFS_TXBUF, rnd());
      rd_chk(`SBM_OFS_FLAGS, 8'h10);
      wr_reg(`SBM_OFS_TXBUF, 8'h55);
      rd_chk(`SBM_OFS_FLAGS, 8'h00);
      rd_chk(`SBM_OFS_TXCTL, 8'h28);
      wait_tx(1'b1);
      @(posedge clk);
      check(last_low, 13 * bl + 1);
      wait_tx(1'b0);
      repeat (bl + bl / 2) @(posedge clk);
      for (i = 0; i < 8; i++)
      begin
         d1[i] = txck_o;
         repeat (bl) @(posedge clk);
      end
      check(d1, 8'h55);
      repeat (2 * bl) @(posedge clk);
      rd_chk(`SBM_OFS_TXCTL, 8'h22);
      rd_chk(`SBM_OFS_FLAGS, 8'h10);
      wr_reg(`SBM_OFS_BAUD, 8'h01);
      rd_chk(`SBM_OFS_BAUD, 8'h41);
      $display("test break done");
      div = 8'h02 | (rnd() & 8'h01);
      wr_reg(`SBM_OFS_DIVL, div);
      for (p = 0; p < 2; p++)
      begin
         pol = p[0];
         wr_reg(`SBM_OFS_BAUD, {3'h0, pol, 4'h0});
         wr_reg(`SBM_OFS_TXCTL, 8'hB0);
         repeat (4) @(posedge clk);
         check({txck_oe, txck_o}, {1'b1, pol});
         pload <= 1'b1;
         @(posedge clk);
         pload <= 1'b0;
         d1 = rnd();
         d2 = rnd();
         wr_reg(`SBM_OFS_TXBUF, d1);
         wr_reg(`SBM_OFS_TXBUF, d2);
         wait_cnt(5'h08);
         check(got, d1);
         wait_cnt(5'h10);
         check(got, d2);
         repeat (20) @(posedge clk);
         check({rxdt_oe, txck_o}, {1'b0, pol});
         rd_chk(`SBM_OFS_TXCTL, 8'hB2);
      end
      $display("test clocked transmit done");
      line_mode <= 2'h0;
      wr_reg(`SBM_OFS_TXCTL, 8'h90);
      pword = rnd();
      pload <= 1'b1;
      @(posedge clk);
      pload <= 1'b0;
      wr_reg(`SBM_OFS_RXCTL, 8'hA0);
      v = 8'h00;
      for (n = 0; v[5] !== 1'b1 && n < 200; n++)
         bus(1'b0, `SBM_OFS_FLAGS, 8'h00);
      rd_chk(`SBM_OFS_RXCTL, 8'h80);
      rd_chk(`SBM_OFS_RXBUF, pword);
      rd_chk(`SBM_OFS_FLAGS, 8'h10);
      wr_reg(`SBM_OFS_RXCTL, 8'h90);
      repeat (400) @(posedge clk);
      rd_chk(`SBM_OFS_RXCTL, 8'h92);
      wr_reg(`SBM_OFS_RXCTL, 8'h80);
      rd_chk(`SBM_OFS_RXCTL, 8'h80);
      bus(1'b0, `SBM_OFS_RXBUF, 8'h00);
      $display("test clocked receive done");
      line_mode <= 2'h2;
      wr_reg(`SBM_OFS_TXCTL, 8'h00);
      wr_reg(`SBM_OFS_BAUD, 8'h02);
      line_mode <= 2'h1;
      repeat (10) @(posedge clk);
      rd_chk(`SBM_OFS_FLAGS, 8'h30);
      line_mode <= 2'h2;
      repeat (10) @(posedge clk);
      rd_chk(`SBM_OFS_BAUD, 8'h40);
      $display("test wake done");
      summarize;
   end
endmodule
`default_nettype wire
